// File: hw/sdram_lp_ctrl.sv
// module: self-refresh and power-down state logic of the sdram device
`timescale 1ns/100ps
// Notes on behaviour
// - cs, ras, cas, cke low with we high at a clock edge enters self-refresh.
// - with locked loop enabled, loop stops on entry and restarts with reset on exit.
// - in self-refresh only cke and reset matter; clock gated; own refresh timer.
// - first internal refresh starts within the minimum cke pulse time.
// - power-down is precharge type if all banks closed, else active type.
// - power-down disables buffers; command receivers off after entry gate delay.
// - slow precharge power-down stops the loop; fast and active keep it.
module sdram_lp_ctrl
   import lp_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic link_clk,
   input wire lp_pkg::cmd_bus_t cmd,
   input wire logic banks_open,
   input wire logic mr0_fast_exit,
   input wire logic mr1_loop_disable,
   output lp_pkg::lp_state_t state,
   output lp_pkg::lp_status_t status,
   output logic cmd_accept_ok,
   output logic dll_cmd_ok
);
   localparam int REFRESH_WIN = MIN_CKE_PULSE_CYC;

   ////////////////////////////////////////////////////////////////////////
   // link side: command bus sampled on link clock, cke then crossed
   cmd_bus_t link_cmd;
   logic link_sre;
   logic link_sre_tog;
   always_ff @(posedge link_clk) begin
      link_cmd <= cmd;
   end
   // decode on the link edge, pass as a toggle event
   always_ff @(posedge link_clk) begin
      if (srst) begin
         link_sre_tog <= 1'b0;
      end else if (link_sre) begin
         link_sre_tog <= ~link_sre_tog;
      end
   end
   assign link_sre = !cmd.cs_n && !cmd.ras_n && !cmd.cas_n && cmd.we_n && !cmd.cke
      && link_cmd.cke;

   ////////////////////////////////////////////////////////////////////////
   // crossings: three flops, change counts when second and third agree
   logic [2:0] cke_sync;
   logic [2:0] sre_sync;
   logic cke;
   logic sre_evt;
   logic sre_prev;
   always_ff @(posedge clk) begin
      cke_sync <= {cke_sync[1:0], link_cmd.cke};
      sre_sync <= {sre_sync[1:0], link_sre_tog};
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         cke <= 1'b1;
      end else if (cke_sync[1] == cke_sync[2]) begin
         cke <= cke_sync[2];
      end
   end
   assign sre_evt = (sre_sync[1] == sre_sync[2]) && (sre_sync[2] != sre_prev);
   always_ff @(posedge clk) begin
      if (srst) begin
         sre_prev <= 1'b0;
      end else if (sre_sync[1] == sre_sync[2]) begin
         sre_prev <= sre_sync[2];
      end
   end
   logic cke_prev;
   always_ff @(posedge clk) begin
      if (srst) begin
         cke_prev <= 1'b1;
      end else begin
         cke_prev <= cke;
      end
   end
   logic cke_fall;
   logic cke_rise;
   assign cke_fall = cke_prev && !cke;
   assign cke_rise = !cke_prev && cke;

   ////////////////////////////////////////////////////////////////////////
   // state machine
   lp_state_t next_state;
   logic [15:0] res_cnt;
   logic [15:0] exit_cnt;
   logic [15:0] gate_cnt;
   logic [15:0] ref_cnt;
   logic loop_on;
   logic exit_slow;
   logic exit_sr;
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (sre_evt) begin
               next_state = ST_SELF_REFRESH;
            end else if (cke_fall) begin
               if (banks_open) begin
                  next_state = ST_ACTIVE_PD;
               end else if (mr0_fast_exit) begin
                  next_state = ST_FAST_PRE_PD;
               end else begin
                  next_state = ST_SLOW_PRE_PD;
               end
            end
         end
         ST_SELF_REFRESH: begin
            // only cke matters here
            if (cke_rise) begin
               next_state = ST_IDLE;
            end
         end
         ST_ACTIVE_PD, ST_FAST_PRE_PD, ST_SLOW_PRE_PD: begin
            if (cke_rise) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counters
   always_ff @(posedge clk) begin
      if (srst) begin
         res_cnt <= CNT_ZERO;
      end else if (state != next_state) begin
         res_cnt <= CNT_ZERO;
      end else if (res_cnt != 16'hFFFF) begin
         res_cnt <= res_cnt + 16'h0001;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         exit_slow <= 1'b0;
      end else if (state != ST_IDLE && next_state == ST_IDLE) begin
         exit_slow <= (state == ST_SELF_REFRESH) || (state == ST_SLOW_PRE_PD);
      end
   end
   // self-refresh exit needs the long delays, power-down exit the short ones
   always_ff @(posedge clk) begin
      if (srst) begin
         exit_sr <= 1'b0;
      end else if (state != ST_IDLE && next_state == ST_IDLE) begin
         exit_sr <= (state == ST_SELF_REFRESH);
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         exit_cnt <= 16'hFFFF;
      end else if (state != ST_IDLE && next_state == ST_IDLE) begin
         exit_cnt <= CNT_ZERO;
      end else if (exit_cnt != 16'hFFFF) begin
         exit_cnt <= exit_cnt + 16'h0001;
      end
   end
   // command receiver gate counted from power-down entry
   always_ff @(posedge clk) begin
      if (srst) begin
         gate_cnt <= CNT_ZERO;
      end else if (state == ST_IDLE) begin
         gate_cnt <= CNT_ZERO;
      end else if (gate_cnt != 16'hFFFF) begin
         gate_cnt <= gate_cnt + 16'h0001;
      end
   end
   // internal refresh timer, first pulse inside minimum cke time
   always_ff @(posedge clk) begin
      if (srst) begin
         ref_cnt <= CNT_ZERO;
      end else if (state != ST_SELF_REFRESH) begin
         ref_cnt <= CNT_ZERO;
      end else if (ref_cnt == 16'(REFRESH_TIMER_CYC - 1)) begin
         ref_cnt <= CNT_ZERO;
      end else begin
         ref_cnt <= ref_cnt + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // locked loop control
   always_ff @(posedge clk) begin
      if (srst) begin
         loop_on <= 1'b0;
      end else if (next_state == ST_SELF_REFRESH || next_state == ST_SLOW_PRE_PD) begin
         loop_on <= 1'b0;
      end else begin
         loop_on <= !mr1_loop_disable;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   always_ff @(posedge clk) begin
      if (srst) begin
         status <= '0;
      end else begin
         status.loop_enabled <= loop_on;
         status.loop_reset <= exit_sr && exit_cnt < 16'(LOOP_RESET_CYC)
            && !mr1_loop_disable;
         status.clock_gated <= (state == ST_SELF_REFRESH);
         status.cmd_receivers_on <= (state == ST_IDLE)
            || (gate_cnt < 16'(PD_ENTRY_GATE_CYC));
         status.io_buffers_on <= (state == ST_IDLE);
         status.refresh_pulse <= (state == ST_SELF_REFRESH)
            && ref_cnt == 16'(REFRESH_TIMER_CYC - 1);
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         cmd_accept_ok <= 1'b1;
         dll_cmd_ok <= 1'b1;
      end else begin
         cmd_accept_ok <= (state == ST_IDLE) && (exit_sr ?
            exit_cnt >= 16'(SR_EXIT_SHORT_CYC) : exit_cnt >= 16'(PD_EXIT_LATENCY_CYC));
         dll_cmd_ok <= (state == ST_IDLE) && (exit_sr ?
            exit_cnt >= 16'(SR_EXIT_LOCKED_LOOP_CYC) : (exit_slow ?
            exit_cnt >= 16'(PD_EXIT_LOCKED_LOOP_LATENCY_CYC)
            : exit_cnt >= 16'(PD_EXIT_LATENCY_CYC)));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   sr_entry_a: assert property (@(posedge clk) disable iff (srst)
      state == ST_IDLE && sre_evt |=> state == ST_SELF_REFRESH)
      else $error("self-refresh entry missed");
   sr_loop_off_a: assert property (@(posedge clk) disable iff (srst)
      state == ST_SELF_REFRESH |-> !loop_on)
      else $error("loop on in self-refresh");
   sr_gate_a: assert property (@(posedge clk) disable iff (srst)
      state == ST_SELF_REFRESH && $past(state == ST_SELF_REFRESH) |-> status.clock_gated)
      else $error("clock not gated");
   sr_refresh_a: assert property (@(posedge clk) disable iff (srst)
      $rose(state == ST_SELF_REFRESH) ##1 (state == ST_SELF_REFRESH)[*7]
      |-> ##[0:REFRESH_WIN] status.refresh_pulse || state != ST_SELF_REFRESH)
      else $error("no internal refresh");
   pd_kind_a: assert property (@(posedge clk) disable iff (srst)
      state == ST_IDLE && !sre_evt && cke_fall && banks_open |=> state == ST_ACTIVE_PD)
      else $error("wrong power-down kind");
   pd_gate_a: assert property (@(posedge clk) disable iff (srst)
      $rose(state != ST_IDLE) ##3 state != ST_IDLE |-> !status.cmd_receivers_on)
      else $error("receivers left on");
   slow_loop_a: assert property (@(posedge clk) disable iff (srst)
      state == ST_SLOW_PRE_PD |-> !loop_on)
      else $error("loop on in slow exit");
   fast_loop_a: assert property (@(posedge clk) disable iff (srst)
      state == ST_FAST_PRE_PD && !mr1_loop_disable && $past(!mr1_loop_disable)
      && $past(state == ST_FAST_PRE_PD) |-> loop_on)
      else $error("loop off in fast exit");
   exit_wait_a: assert property (@(posedge clk) disable iff (srst)
      $fell(state == ST_ACTIVE_PD) |-> !cmd_accept_ok [*2])
      else $error("command allowed too early");
   sr_exit_wait_a: assert property (@(posedge clk) disable iff (srst)
      $fell(state == ST_SELF_REFRESH) |-> !cmd_accept_ok [*8])
      else $error("command allowed too early after self-refresh");
   sr_dll_wait_a: assert property (@(posedge clk) disable iff (srst)
      $fell(state == ST_SELF_REFRESH) |-> !dll_cmd_ok [*8])
      else $error("loop command allowed too early after self-refresh");
   slow_dll_wait_a: assert property (@(posedge clk) disable iff (srst)
      $fell(state == ST_SLOW_PRE_PD) |-> !dll_cmd_ok [*8])
      else $error("loop command allowed too early after slow exit");
   pd_io_off_a: assert property (@(posedge clk) disable iff (srst)
      state != ST_IDLE && $past(state != ST_IDLE) |-> !status.io_buffers_on)
      else $error("buffers left on");
   sr_cov_c: cover property (@(posedge clk) disable iff (srst)
      state == ST_SELF_REFRESH ##[1:200] state == ST_IDLE);
   apd_cov_c: cover property (@(posedge clk) state == ST_ACTIVE_PD);
   spd_cov_c: cover property (@(posedge clk) state == ST_SLOW_PRE_PD);
   fpd_cov_c: cover property (@(posedge clk) state == ST_FAST_PRE_PD);
   spd_exit_c: cover property (@(posedge clk) $fell(state == ST_SLOW_PRE_PD));

endmodule // sdram_lp_ctrl

// File: hw/lp_pkg.sv
// package: constants and types for the sdram low-power state block
package lp_pkg;
   localparam int CLK_MHZ = 20;
   localparam int MIN_CKE_PULSE_NS = 5000;
   localparam int MIN_CKE_PULSE_CYC = (MIN_CKE_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int SR_MIN_RESIDENCY_NS = 10000;
   localparam int SR_MIN_RESIDENCY_CYC = (SR_MIN_RESIDENCY_NS * CLK_MHZ + 999) / 1000;
   localparam int PD_ENTRY_GATE_CYC = 1;
   localparam int SR_EXIT_SHORT_NS = 2000;
   localparam int SR_EXIT_SHORT_CYC = (SR_EXIT_SHORT_NS * CLK_MHZ + 999) / 1000;
   localparam int SR_EXIT_LOCKED_LOOP_CYC = 512;
   localparam int PD_EXIT_LATENCY_CYC = 3;
   localparam int PD_EXIT_LOCKED_LOOP_LATENCY_CYC = 10;
   localparam int LOOP_RESET_CYC = 4;
   localparam int REFRESH_TIMER_CYC = 64;
   localparam int MR0_FAST_EXIT_BIT = 12;
   localparam int MR1_LOOP_DISABLE_BIT = 0;
   localparam logic [2:0] RESET_STATE_BITS = 3'h0;
   localparam logic [15:0] CNT_ZERO = 16'h0000;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_SELF_REFRESH = 5'h02,
      ST_ACTIVE_PD = 5'h04,
      ST_FAST_PRE_PD = 5'h08,
      ST_SLOW_PRE_PD = 5'h10
   } lp_state_t;

   typedef struct packed {
      logic cke;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic odt;
   } cmd_bus_t;

   typedef struct packed {
      logic loop_enabled;
      logic loop_reset;
      logic clock_gated;
      logic cmd_receivers_on;
      logic io_buffers_on;
      logic refresh_pulse;
   } lp_status_t;
endpackage : lp_pkg

// File: tb/lp_ctrl_model.sv
// controller-side model driving cke, command and odt on the link clock
`timescale 1ns/100ps
module lp_ctrl_model
   import lp_pkg::*;
(
   input wire logic link_clk,
   input wire logic srst,
   input wire logic go_low,
   input wire logic use_sre,
   output cmd_bus_t cmd
);
   logic [3:0] low_cnt;
   always_ff @(posedge link_clk) begin
      if (srst) begin
         cmd <= 6'h2E;
         low_cnt <= 4'h0;
      end else if (cmd.cke && go_low) begin
         // odt already low when entry is asked for; banks idle except on active power-down entry
         cmd <= use_sre ? 6'h02 : 6'h0E;
         low_cnt <= 4'h0;
      end else if (!cmd.cke && go_low) begin
         // nop through the gate delay, then junk that the device must ignore
         low_cnt <= low_cnt + 4'h1;
         if (low_cnt >= 4'h2) begin
            cmd <= {1'h0, low_cnt, ~low_cnt[0]};
         end else begin
            cmd <= 6'h0E;
         end
      end else begin
         cmd <= 6'h2E;
      end
   end
endmodule // lp_ctrl_model

// File: tb/tb_sdram_lp_ctrl.sv
// self-checking bench for the sdram low-power state block
`timescale 1ns/100ps
module tb_sdram_lp_ctrl;
   import lp_pkg::*;
   logic clk = 1'h0;
   logic link_clk = 1'h0;
   logic srst = 1'h1;
   logic banks_open = 1'h0;
   logic mr0_fast_exit = 1'h0;
   logic mr1_loop_disable = 1'h0;
   logic go_low = 1'h0;
   logic use_sre = 1'h0;
   cmd_bus_t cmd;
   lp_state_t state;
   lp_status_t status;
   logic cmd_accept_ok;
   logic dll_cmd_ok;
   int fails = 0;
   int checks = 0;
   int seed = 95;
   int i;
   int n;
   int m;
   always #25 clk = ~clk;
   initial begin
      #7;
      forever #80 link_clk = ~link_clk;
   end
   sdram_lp_ctrl dut (.clk(clk), .srst(srst), .link_clk(link_clk), .cmd(cmd),
      .banks_open(banks_open), .mr0_fast_exit(mr0_fast_exit),
      .mr1_loop_disable(mr1_loop_disable), .state(state), .status(status),
      .cmd_accept_ok(cmd_accept_ok), .dll_cmd_ok(dll_cmd_ok));
   lp_ctrl_model ctrl (.link_clk(link_clk), .srst(srst), .go_low(go_low),
      .use_sre(use_sre), .cmd(cmd));
   ////////////////////////////////////////////////////////////////////////////
   function automatic lp_state_t pd_state(input logic open, input logic fast);
      return open ? ST_ACTIVE_PD : (fast ? ST_FAST_PRE_PD : ST_SLOW_PRE_PD);
   endfunction
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string nm);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   task automatic conclude;
      if (fails == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic wait_state(input lp_state_t exp, input int lim);
      int k;
      k = 0;
      while (state !== exp && k < lim) begin
         cyc(1);
         k++;
      end
      cmp(8'(state), 8'(exp), "state");
      if (state !== exp) conclude();
   endtask
   task automatic wait_ok(input logic sel, input int lim);
      int k;
      k = 0;
      while ((sel ? dll_cmd_ok : cmd_accept_ok) !== 1'h1 && k < lim) begin
         cyc(1);
         k++;
      end
      cmp({7'h00, sel ? dll_cmd_ok : cmd_accept_ok}, 8'h01,
         sel ? "dll_cmd_ok" : "cmd_accept_ok");
      if ((sel ? dll_cmd_ok : cmd_accept_ok) !== 1'h1) conclude();
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(5);
      srst = 1'h0;
      cyc(4);
      // self-refresh entry, residency with junk inputs, exit
      use_sre = 1'h1;
      go_low = 1'h1;
      wait_state(ST_SELF_REFRESH, 40);
      cyc(2);
      cmp(8'(status.clock_gated), 8'h01, "clock_gated");
      cmp(8'(status.loop_enabled), 8'h00, "loop_enabled");
      n = 0;
      for (i = 0; i < MIN_CKE_PULSE_CYC; i++) begin
         cyc(1);
         banks_open = 1'($random(seed));
         mr0_fast_exit = 1'($random(seed));
         n += (status.refresh_pulse === 1'h1);
      end
      cmp(8'(n != 0), 8'h01, "refresh_pulse");
      cyc(SR_MIN_RESIDENCY_CYC + ($random(seed) & 15));
      cmp(8'(state), 8'(ST_SELF_REFRESH), "state");
      banks_open = 1'h0;
      go_low = 1'h0;
      n = 0;
      for (i = 0; i < 20; i++) begin
         cyc(1);
         n += (status.loop_reset === 1'h1);
      end
      cmp(8'(state), 8'(ST_IDLE), "state");
      cmp(8'(n), 8'(LOOP_RESET_CYC), "loop_reset");
      cmp(8'(status.loop_enabled), 8'h01, "loop_enabled");
      cmp(8'(cmd_accept_ok), 8'h00, "cmd_accept_ok");
      wait_ok(1'h0, SR_EXIT_SHORT_CYC);
      cmp(8'(dll_cmd_ok), 8'h00, "dll_cmd_ok");
      wait_ok(1'h1, SR_EXIT_LOCKED_LOOP_CYC);
      cyc(MIN_CKE_PULSE_CYC);
      // active, fast and slow power-down in turn
      use_sre = 1'h0;
      for (m = 0; m < 3; m++) begin
         banks_open = (m == 0);
         mr0_fast_exit = (m == 1) | ((m == 0) & 1'($random(seed)));
         go_low = 1'h1;
         wait_state(pd_state(banks_open, mr0_fast_exit), 40);
         cyc(PD_ENTRY_GATE_CYC + 2);
         cmp(8'(status.cmd_receivers_on), 8'h00, "cmd_receivers_on");
         cmp(8'(status.io_buffers_on), 8'h00, "io_buffers_on");
         cmp(8'(status.loop_enabled), 8'(m != 2), "loop_enabled");
         cyc(MIN_CKE_PULSE_CYC);
         cmp(8'(state), 8'(pd_state(m == 0, m != 2)), "state");
         go_low = 1'h0;
         wait_state(ST_IDLE, 40);
         wait_ok(1'h0, PD_EXIT_LATENCY_CYC + 8);
         wait_ok(1'h1, PD_EXIT_LOCKED_LOOP_LATENCY_CYC + 8);
         cyc(MIN_CKE_PULSE_CYC);
      end
      conclude();
   end
endmodule // tb_sdram_lp_ctrl
